// ===== ecrpc_pkg.sv
/*
 * Constants for the glass control, recovery and PWM gating register bank:
 * serial frame layout, register addresses, field positions and timing.
 * Assumes a 200 MHz system clock and a serial master on slow pins.
 */
package ecrpc_pkg;

   // ==========================================================
   // Clock and timing
   localparam int CLK_PERIOD_NS    = 5;
   localparam int REC_SLOW_HZ      = 1700;
   localparam int REC_FAST_HZ      = 3000;
   localparam int REC_SLOW_NS      = 1000000000 / REC_SLOW_HZ;
   localparam int REC_FAST_NS      = 1000000000 / REC_FAST_HZ;
   localparam int REC_SLOW_CYC     = REC_SLOW_NS / CLK_PERIOD_NS;
   localparam int REC_FAST_CYC     = REC_FAST_NS / CLK_PERIOD_NS;
   localparam int REC_CNT_W        = 20;

   // ==========================================================
   // Serial frame: 2 op bits, 6 address bits, 16 data bits
   localparam int FRAME_BITS       = 24;
   localparam int HDR_BITS         = 8;
   localparam int BITCNT_W         = 5;
   localparam logic [1:0] OP_WRITE = 2'h0;
   localparam logic [1:0] OP_READ  = 2'h1;

   // ==========================================================
   // Register addresses
   localparam logic [5:0] ADDR_CTRL1  = 6'h01;
   localparam logic [5:0] ADDR_CTRL2  = 6'h02;
   localparam logic [5:0] ADDR_STATUS = 6'h10;
   localparam logic [15:0] CTRL_RESET = 16'h0000;

   // ==========================================================
   // First control word fields
   localparam int C1_REF_MSB       = 7;
   localparam int C1_REF_LSB       = 2;
   localparam int C1_GLASS_EN      = 1;
   localparam int C1_RSVD          = 0;
   localparam int C1_HS_J_ON       = 10;
   localparam int C1_DISCHARGE     = 8;

   // ==========================================================
   // Second control word fields
   localparam int C2_REC_EN_TOP    = 15;
   localparam int C2_GLASS_REC_EN  = 9;
   localparam int C2_RSVD          = 8;
   localparam int C2_PWM_EN_TOP    = 7;
   localparam int C2_GLASS_PWM_EN  = 1;
   localparam int C2_FULL_SCALE    = 0;
   localparam int PWM_B_BRIDGE     = 4;

   // ==========================================================
   // Channels: six half bridges then the glass output
   localparam int NUM_BRIDGES      = 6;
   localparam int NUM_CH           = 7;
   localparam int GLASS_CH         = 6;
   localparam int REF_W            = 6;

   // ==========================================================
   // Glass target voltage in millivolts
   localparam logic [11:0] FS_HIGH_MV = 12'd1500;
   localparam logic [11:0] FS_LOW_MV  = 12'd1200;
   localparam logic [17:0] REF_STEPS  = 18'd63;
   localparam int MV_W                = 12;

endpackage

// ===== ecrpc_regbank.sv
/*
 * Register bank for glass voltage control, over-current auto recovery
 * and PWM gating of the half bridges and high-side outputs.
 * Assumes a serial master on sck/cs_n/mosi pins asynchronous to clock_in,
 * and upstream logic providing the other on/off and configuration bits.
 */
// How it works
// RULE1 - Bits 7:2 of word one are glass code
// RULE2 - All-zero code commands zero volts target
// RULE3 - Discharge bit turns on glass low switch
// RULE4 - Glass enable activates regulation and gate drive
// RULE5 - Glass enable forces highside_j on always
// RULE6 - Master writes zero into reserved bits
// RULE7 - Over-current sets flag, switches output off
// RULE8 - Recovery enable reactivates output after delay
// RULE9 - Late event may still give one recovery
// RULE10 - Glass mode ignores glass recovery enable
// RULE11 - PWM enable gates output by PWM input
// RULE12 - Bridge e, h, j use input b
// RULE13 - Full-scale bit selects 1.5 or 1.2 V
// RULE14 - On bit set switches driver on
// RULE15 - Both bridge bits set: neither conducts
// RULE16 - Recovery rate 1.7 kHz or 3 kHz
// RULE17 - New words applied only after clean frame
// RULE18 - Glass disabled: gate off, j normal
module ecrpc_regbank
   import ecrpc_pkg::*;
#(
   parameter int REC_SLOW_CYCLES = REC_SLOW_CYC,
   parameter int REC_FAST_CYCLES = REC_FAST_CYC
) (
   // Clock and reset
   input  wire logic                  clock_in,
   input  wire logic                  sys_rst_in,
   // Serial port pins
   input  wire logic                  spi_sck_in,
   input  wire logic                  spi_cs_n_in,
   input  wire logic                  spi_mosi_in,
   output logic                       spi_miso_out,
   output logic                       spi_miso_oe_out,
   // On/off and config bits held elsewhere
   input  wire logic [NUM_BRIDGES-1:0] bridge_hs_on_in,
   input  wire logic [NUM_BRIDGES-1:0] bridge_ls_on_in,
   input  wire logic                  highside_h_on_in,
   input  wire logic                  highside_h_pwm_en_in,
   input  wire logic                  highside_j_pwm_en_in,
   input  wire logic                  recovery_fast_in,
   // PWM and over-current inputs
   input  wire logic                  pwm_input_a_in,
   input  wire logic                  pwm_input_b_in,
   input  wire logic [NUM_CH-1:0]     overcurrent_in,
   input  wire logic [NUM_CH-1:0]     oc_status_clear_in,
   // Driver controls
   output logic [NUM_BRIDGES-1:0]     bridge_hs_gate_out,
   output logic [NUM_BRIDGES-1:0]     bridge_ls_gate_out,
   output logic                       highside_h_gate_out,
   output logic                       highside_j_gate_out,
   output logic                       glass_discharge_switch_on_out,
   // Glass regulation
   output logic                       ext_fet_gate_drive_out,
   output logic                       glass_control_enable_out,
   output logic [REF_W-1:0]           glass_ref_code_out,
   output logic                       glass_full_scale_select_out,
   output logic [MV_W-1:0]            glass_target_mv_out,
   // Status
   output logic [NUM_CH-1:0]          oc_status_out
);

   // ==========================================================
   // Pin synchronisers
   logic [2:0] sck_sync_q;
   logic [1:0] cs_sync_q;
   logic [1:0] mosi_sync_q;
   logic [NUM_CH-1:0] oc_meta_q;
   logic [NUM_CH-1:0] oc_sync_q;
   logic cs_n_prev_q;

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         sck_sync_q  <= 3'h0;
         cs_sync_q   <= 2'h3;
         mosi_sync_q <= 2'h0;
         oc_meta_q   <= '0;
         oc_sync_q   <= '0;
         cs_n_prev_q <= 1'b1;
      end else begin
         sck_sync_q  <= {sck_sync_q[1:0], spi_sck_in};
         cs_sync_q   <= {cs_sync_q[0], spi_cs_n_in};
         mosi_sync_q <= {mosi_sync_q[0], spi_mosi_in};
         oc_meta_q   <= overcurrent_in;
         oc_sync_q   <= oc_meta_q;
         cs_n_prev_q <= cs_sync_q[1];
      end
   end

   logic cs_n;
   logic sck_rise;
   logic sck_fall;
   logic frame_start;
   logic frame_end;
   assign cs_n        = cs_sync_q[1];
   assign sck_rise    = sck_sync_q[1] & ~sck_sync_q[2];
   assign sck_fall    = ~sck_sync_q[1] & sck_sync_q[2];
   assign frame_start = cs_n_prev_q & ~cs_n;
   assign frame_end   = ~cs_n_prev_q & cs_n;

   // ==========================================================
   // Serial shift engine
   logic [FRAME_BITS-1:0] rx_q;
   logic [BITCNT_W-1:0]   bitcnt_q;
   logic                  overrun_q;
   logic [15:0]           tx_q;
   logic [15:0]           ctrl1_q;
   logic [15:0]           ctrl2_q;
   logic [15:0]           rd_data;
   logic [NUM_CH-1:0]     oc_flag_q;

   always_comb begin
      case (rx_q[REF_W-1:0])
         ADDR_CTRL1:  rd_data = ctrl1_q;
         ADDR_CTRL2:  rd_data = ctrl2_q;
         ADDR_STATUS: rd_data = {{(16-NUM_CH){1'b0}}, oc_flag_q};
         default:     rd_data = 16'h0000;
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         rx_q      <= '0;
         bitcnt_q  <= '0;
         overrun_q <= 1'b0;
      end else if (frame_start) begin
         bitcnt_q  <= '0;
         overrun_q <= 1'b0;
      end else if (~cs_n && sck_rise) begin
         rx_q <= {rx_q[FRAME_BITS-2:0], mosi_sync_q[1]};
         if (bitcnt_q == BITCNT_W'(FRAME_BITS))
            overrun_q <= 1'b1;
         else
            bitcnt_q <= bitcnt_q + 1'b1;
      end
   end

   // Reply data loaded once the header is in, shifted on falling edges
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         tx_q <= 16'h0000;
      end else if (frame_start) begin
         tx_q <= 16'h0000;
      end else if (~cs_n && sck_rise
                   && bitcnt_q == BITCNT_W'(HDR_BITS - 1)) begin
         tx_q <= '0;
      end else if (~cs_n && sck_fall
                   && bitcnt_q == BITCNT_W'(HDR_BITS)) begin
         tx_q <= {rd_data[14:0], 1'b0};
      end else if (~cs_n && sck_fall) begin
         tx_q <= {tx_q[14:0], 1'b0};
      end
   end

   logic miso_q;
   always_ff @(posedge clock_in) begin
      if (sys_rst_in)
         miso_q <= 1'b0;
      else if (~cs_n && sck_fall && bitcnt_q == BITCNT_W'(HDR_BITS))
         miso_q <= rd_data[15];
      else if (~cs_n && sck_fall)
         miso_q <= tx_q[15];
   end
   assign spi_miso_out    = miso_q;
   assign spi_miso_oe_out = ~cs_n;

   // ==========================================================
   // Control words: committed only on a complete, exact frame
   logic commit;
   assign commit = frame_end && ~overrun_q                      // RULE17
                   && bitcnt_q == BITCNT_W'(FRAME_BITS)
                   && rx_q[FRAME_BITS-1 -: 2] == OP_WRITE;

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         ctrl1_q <= CTRL_RESET;
         ctrl2_q <= CTRL_RESET;
      end else if (commit) begin
         // Reserved bits kept at zero whatever the master sends
         if (rx_q[FRAME_BITS-3 -: REF_W] == ADDR_CTRL1)
            ctrl1_q <= rx_q[15:0] & ~(16'h0001 << C1_RSVD);     // RULE6
         if (rx_q[FRAME_BITS-3 -: REF_W] == ADDR_CTRL2)
            ctrl2_q <= rx_q[15:0] & ~(16'h0001 << C2_RSVD);     // RULE6
      end
   end

   // ==========================================================
   // Glass regulation
   logic glass_en;
   logic [REF_W-1:0] ref_code;
   logic [17:0] target_full;
   assign glass_en = ctrl1_q[C1_GLASS_EN];
   assign ref_code = ctrl1_q[C1_REF_MSB:C1_REF_LSB];            // RULE1
   // Same step size in both ranges; low range just clips the top
   assign target_full = (18'(ref_code) * 18'(FS_HIGH_MV))
                        / REF_STEPS;                            // RULE2

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         ext_fet_gate_drive_out      <= 1'b0;
         glass_control_enable_out    <= 1'b0;
         glass_ref_code_out          <= '0;
         glass_full_scale_select_out <= 1'b0;
         glass_target_mv_out         <= '0;
      end else begin
         ext_fet_gate_drive_out      <= glass_en;               // RULE4 RULE18
         glass_control_enable_out    <= glass_en;               // RULE4
         glass_ref_code_out          <= ref_code;               // RULE1
         glass_full_scale_select_out <= ctrl2_q[C2_FULL_SCALE]; // RULE13
         if (~ctrl2_q[C2_FULL_SCALE]
             && target_full > 18'(FS_LOW_MV))
            glass_target_mv_out <= FS_LOW_MV;                   // RULE13
         else
            glass_target_mv_out <= target_full[MV_W-1:0];       // RULE2
      end
   end

   // ==========================================================
   // Recovery timebase
   logic [REC_CNT_W-1:0] rec_cnt_q;
   logic [REC_CNT_W-1:0] rec_period;
   logic rec_tick;
   logic rec_late;
   assign rec_period = recovery_fast_in                          // RULE16
                       ? REC_CNT_W'(REC_FAST_CYCLES)
                       : REC_CNT_W'(REC_SLOW_CYCLES);
   assign rec_tick   = rec_cnt_q >= rec_period - 1'b1;
   // Second half of the period: too late to cancel the pending retry
   assign rec_late   = rec_cnt_q >= (rec_period >> 1);

   always_ff @(posedge clock_in) begin
      if (sys_rst_in || rec_tick)
         rec_cnt_q <= '0;
      else
         rec_cnt_q <= rec_cnt_q + 1'b1;
   end

   // ==========================================================
   // Per-channel over-current, recovery and PWM gating
   logic [NUM_CH-1:0] ch_cmd;
   logic [NUM_CH-1:0] ch_on;
   logic [NUM_CH-1:0] off_q;
   logic [NUM_CH-1:0] late_q;

   generate
      for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
         logic rec_en;
         logic pwm_en;
         logic pwm_sel;
         if (i == GLASS_CH) begin : g_glass
            assign ch_cmd[i] = ctrl1_q[C1_DISCHARGE];           // RULE3
            assign rec_en  = ctrl2_q[C2_GLASS_REC_EN]
                             & ~glass_en;                       // RULE10
            assign pwm_en  = ctrl2_q[C2_GLASS_PWM_EN];
            assign pwm_sel = pwm_input_a_in;
         end else begin : g_bridge
            assign ch_cmd[i] = bridge_hs_on_in[i]
                               ^ bridge_ls_on_in[i];            // RULE15
            assign rec_en  = ctrl2_q[C2_REC_EN_TOP - i];        // RULE8
            assign pwm_en  = ctrl2_q[C2_PWM_EN_TOP - i];
            assign pwm_sel = (i == PWM_B_BRIDGE)
                             ? pwm_input_b_in
                             : pwm_input_a_in;                  // RULE12
         end

         always_ff @(posedge clock_in) begin
            if (sys_rst_in) begin
               off_q[i]  <= 1'b0;
               late_q[i] <= 1'b0;
            end else if (oc_sync_q[i] && ch_cmd[i] && ~off_q[i]) begin
               off_q[i]  <= 1'b1;                               // RULE7
               late_q[i] <= rec_late;                           // RULE9
            end else if (~ch_cmd[i]) begin
               off_q[i]  <= 1'b0;
               late_q[i] <= 1'b0;
            end else if (rec_tick && off_q[i]) begin
               off_q[i]  <= ~(rec_en | late_q[i]);              // RULE8 RULE9
               late_q[i] <= 1'b0;
            end
         end

         // Sticky flag: a new event beats a clear in the same cycle
         always_ff @(posedge clock_in) begin
            if (sys_rst_in)
               oc_flag_q[i] <= 1'b0;
            else if (oc_sync_q[i] && ch_cmd[i])
               oc_flag_q[i] <= 1'b1;                            // RULE7
            else if (oc_status_clear_in[i])
               oc_flag_q[i] <= 1'b0;
         end

         assign ch_on[i] = ch_cmd[i] & ~off_q[i]                // RULE14
                           & (~pwm_en | pwm_sel);               // RULE11
      end
   endgenerate

   assign oc_status_out = oc_flag_q;

   // ==========================================================
   // Output stage registers
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         bridge_hs_gate_out            <= '0;
         bridge_ls_gate_out            <= '0;
         glass_discharge_switch_on_out <= 1'b0;
         highside_h_gate_out           <= 1'b0;
         highside_j_gate_out           <= 1'b0;
      end else begin
         bridge_hs_gate_out <= ch_on[NUM_BRIDGES-1:0]
                               & bridge_hs_on_in;               // RULE15
         bridge_ls_gate_out <= ch_on[NUM_BRIDGES-1:0]
                               & bridge_ls_on_in;               // RULE15
         glass_discharge_switch_on_out <= ch_on[GLASS_CH];      // RULE3
         highside_h_gate_out <= highside_h_on_in
                                & (~highside_h_pwm_en_in
                                   | pwm_input_b_in);           // RULE12
         // Glass mode overrides both the on bit and PWM gating
         highside_j_gate_out <= glass_en                        // RULE5
                                | (ctrl1_q[C1_HS_J_ON]
                                   & (~highside_j_pwm_en_in
                                      | pwm_input_b_in));       // RULE18
      end
   end

endmodule

// ===== ecrpc_regbank_asserts.sv
/*
 Port-level checks for the glass, recovery and PWM register bank.
 Assumes one clock domain with synchronous active-high reset.
*/
module ecrpc_regbank_asserts
   import ecrpc_pkg::*;
(
   // Clock and reset
   input wire logic                   clock_in,
   input wire logic                   sys_rst_in,
   // Driver inputs
   input wire logic [NUM_BRIDGES-1:0] bridge_hs_on_in,
   input wire logic [NUM_BRIDGES-1:0] bridge_ls_on_in,
   input wire logic                   highside_h_on_in,
   input wire logic                   highside_h_pwm_en_in,
   input wire logic                   highside_j_pwm_en_in,
   input wire logic                   pwm_input_b_in,
   input wire logic [NUM_CH-1:0]      oc_status_clear_in,
   // Driver and glass outputs
   input wire logic [NUM_BRIDGES-1:0] bridge_hs_gate_out,
   input wire logic [NUM_BRIDGES-1:0] bridge_ls_gate_out,
   input wire logic                   highside_h_gate_out,
   input wire logic                   highside_j_gate_out,
   input wire logic                   ext_fet_gate_drive_out,
   input wire logic                   glass_control_enable_out,
   input wire logic [REF_W-1:0]       glass_ref_code_out,
   input wire logic                   glass_full_scale_select_out,
   input wire logic [MV_W-1:0]        glass_target_mv_out,
   input wire logic [NUM_CH-1:0]      oc_status_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   int exp_mv;
   // ==========================================================
   // Expected glass target, truncated like the converter scale
   always_comb begin
      exp_mv = int'(glass_ref_code_out) * int'(FS_HIGH_MV) / int'(REF_STEPS);
      if (!glass_full_scale_select_out && exp_mv > int'(FS_LOW_MV))
         exp_mv = int'(FS_LOW_MV);
   end
   // ==========================================================
   // Assertions
   fet_follows_en_a:
      assert property (ext_fet_gate_drive_out == glass_control_enable_out)
      else $error("gate drive differs from glass enable");
   j_forced_on_a:
      assert property (glass_control_enable_out |-> highside_j_gate_out)
      else $error("highside j off in glass mode");
   j_normal_gate_a:
      assert property (!glass_control_enable_out && highside_j_gate_out
         |-> !$past(highside_j_pwm_en_in) || $past(pwm_input_b_in))
      else $error("highside j on while its pwm input low");
   h_pwm_gate_a:
      assert property (highside_h_gate_out |-> $past(highside_h_on_in)
         && (!$past(highside_h_pwm_en_in) || $past(pwm_input_b_in)))
      else $error("highside h on without on bit or pwm input");
   on_bit_gate_a:
      assert property (((bridge_hs_gate_out & ~$past(bridge_hs_on_in)) |
         (bridge_ls_gate_out & ~$past(bridge_ls_on_in))) == 6'h00)
      else $error("bridge gate on without its on bit");
   no_shoot_a:
      assert property (($past(bridge_hs_on_in) & $past(bridge_ls_on_in) &
         (bridge_hs_gate_out | bridge_ls_gate_out)) == 6'h00)
      else $error("bridge with both bits set still conducts");
   zero_code_a:
      assert property (glass_ref_code_out == 6'h00
         |-> glass_target_mv_out == 12'h000)
      else $error("zero code gives nonzero target");
   mv_scale_a:
      assert property (glass_target_mv_out == exp_mv[11:0])
      else $error("glass target voltage wrong");
   flag_sticky_a:
      assert property (!$past(sys_rst_in) |-> ($past(oc_status_out) &
         ~$past(oc_status_clear_in) & ~oc_status_out) == 7'h00)
      else $error("over-current flag lost without clear");
   oc_gate_off_a:
      assert property ($rose(oc_status_out[0]) |=> !bridge_hs_gate_out[0])
      else $error("bridge a still on after over-current");
endmodule

bind ecrpc_regbank ecrpc_regbank_asserts u_ecrpc_regbank_asserts (
   .clock_in(clock_in), .sys_rst_in(sys_rst_in),
   .bridge_hs_on_in(bridge_hs_on_in), .bridge_ls_on_in(bridge_ls_on_in),
   .highside_h_on_in(highside_h_on_in),
   .highside_h_pwm_en_in(highside_h_pwm_en_in),
   .highside_j_pwm_en_in(highside_j_pwm_en_in),
   .pwm_input_b_in(pwm_input_b_in), .oc_status_clear_in(oc_status_clear_in),
   .bridge_hs_gate_out(bridge_hs_gate_out),
   .bridge_ls_gate_out(bridge_ls_gate_out),
   .highside_h_gate_out(highside_h_gate_out),
   .highside_j_gate_out(highside_j_gate_out),
   .ext_fet_gate_drive_out(ext_fet_gate_drive_out),
   .glass_control_enable_out(glass_control_enable_out),
   .glass_ref_code_out(glass_ref_code_out),
   .glass_full_scale_select_out(glass_full_scale_select_out),
   .glass_target_mv_out(glass_target_mv_out), .oc_status_out(oc_status_out)
);

// ===== ecrpc_spi_master.sv
/*
 Serial master model for the register bank's frame pins.
 Assumes the bench clock; frames are started from bench tasks.
*/
module ecrpc_spi_master (
   // Clock and answer line
   input  wire logic clock_in,
   input  wire logic spi_miso_in,
   input  wire logic spi_miso_oe_in,
   // Frame pins
   output logic      spi_sck_out,
   output logic      spi_cs_n_out,
   output logic      spi_mosi_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Half period well above the pin synchroniser delay
   localparam int HALF = 6;
   logic rd_last = 1'b0;
   initial begin
      spi_sck_out = 1'b0;
      spi_cs_n_out = 1'b1;
      spi_mosi_out = 1'b0;
   end
   // ==========================================================
   // One frame, top nbits of the 24-bit vector, MSB first
   task automatic xfer(input logic [23:0] frame, input int nbits,
                       output logic [15:0] rd);
      logic bit_v;
      rd = 16'h0000;
      @(posedge clock_in);
      spi_cs_n_out <= 1'b0;
      repeat (HALF) @(posedge clock_in);
      for (int i = 23; i > 23 - nbits; i--) begin
         spi_sck_out <= 1'b0;
         spi_mosi_out <= frame[i];
         repeat (HALF) @(posedge clock_in);
         // Undriven answer line never repeats the last bit
         bit_v = spi_miso_oe_in ? spi_miso_in : ~rd_last;
         if (i < 16)
            rd[i] = bit_v;
         rd_last = bit_v;
         spi_sck_out <= 1'b1;
         repeat (HALF) @(posedge clock_in);
      end
      spi_sck_out <= 1'b0;
      repeat (HALF) @(posedge clock_in);
      spi_cs_n_out <= 1'b1;
      spi_mosi_out <= ~spi_mosi_out;
      repeat (12) @(posedge clock_in);
   endtask
endmodule

// ===== test_ecrpc_regbank.sv
/*
 Self-checking bench for the register bank, driven by a serial master.
 Assumes recovery periods shortened by parameter for simulation.
*/
module test_ecrpc_regbank
   import ecrpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SLOW = 40;
   localparam int FAST = 20;
   logic        clock_in = 1'b0;
   logic        sys_rst_in = 1'b1;
   logic        sck, cs_n, mosi, miso, miso_oe;
   logic [5:0]  hs_on = 6'h00;
   logic [5:0]  ls_on = 6'h00;
   logic        h_on = 1'b0;
   logic        h_pwm = 1'b0;
   logic        j_pwm = 1'b0;
   logic        rec_fast = 1'b0;
   logic        pwm_a = 1'b0;
   logic        pwm_b = 1'b0;
   logic [6:0]  oc = 7'h00;
   logic [6:0]  oc_clr = 7'h00;
   logic [5:0]  hs_g, ls_g, ref_c;
   logic        h_g, j_g, dis_g, fet, gl_en, fs;
   logic [11:0] mv;
   logic [6:0]  oc_st;
   int          miscompares = 0;
   int          num_checks = 0;
   always #2.5 clock_in = ~clock_in;
   ecrpc_regbank #(.REC_SLOW_CYCLES(SLOW), .REC_FAST_CYCLES(FAST))
   u_ecrpc_regbank (
      .clock_in(clock_in), .sys_rst_in(sys_rst_in), .spi_sck_in(sck),
      .spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso),
      .spi_miso_oe_out(miso_oe), .bridge_hs_on_in(hs_on),
      .bridge_ls_on_in(ls_on), .highside_h_on_in(h_on),
      .highside_h_pwm_en_in(h_pwm), .highside_j_pwm_en_in(j_pwm),
      .recovery_fast_in(rec_fast), .pwm_input_a_in(pwm_a),
      .pwm_input_b_in(pwm_b), .overcurrent_in(oc),
      .oc_status_clear_in(oc_clr), .bridge_hs_gate_out(hs_g),
      .bridge_ls_gate_out(ls_g), .highside_h_gate_out(h_g),
      .highside_j_gate_out(j_g), .glass_discharge_switch_on_out(dis_g),
      .ext_fet_gate_drive_out(fet), .glass_control_enable_out(gl_en),
      .glass_ref_code_out(ref_c), .glass_full_scale_select_out(fs),
      .glass_target_mv_out(mv), .oc_status_out(oc_st));
   ecrpc_spi_master u_ecrpc_spi_master (
      .clock_in(clock_in), .spi_miso_in(miso), .spi_miso_oe_in(miso_oe),
      .spi_sck_out(sck), .spi_cs_n_out(cs_n), .spi_mosi_out(mosi));
   // ==========================================================
   // Shared tasks
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check_val(input logic [15:0] got, exp, input string m);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s %h/%h", $time, m, got, exp);
      end
   endtask
   task automatic clk(input int n);
      repeat (n) @(posedge clock_in);
   endtask
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      logic [15:0] r;
      if (a == ADDR_CTRL1) d[C1_RSVD] = 1'b0;
      if (a == ADDR_CTRL2) d[C2_RSVD] = 1'b0;
      u_ecrpc_spi_master.xfer({OP_WRITE, a, d}, FRAME_BITS, r);
      clk(1);
   endtask
   task automatic rd_chk(input logic [5:0] a, input logic [15:0] e);
      logic [15:0] r;
      u_ecrpc_spi_master.xfer({OP_READ, a, 16'h0000}, FRAME_BITS, r);
      check_val(r, e, "read back");
   endtask
   task automatic wait_g0(input logic lvl, inout int n);
      while (hs_g[0] !== lvl && n < 300) begin
         clk(1);
         n++;
      end
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_glass();
      logic [5:0] codes [4] = '{6'h00, 6'h01, 6'h2a, 6'h3f};
      int e;
      for (int f = 0; f < 2; f++) begin
         wr(ADDR_CTRL2, {15'h0000, f[0]});
         for (int k = 0; k < 4; k++) begin
            wr(ADDR_CTRL1, {8'h00, codes[k], 2'b10});
            e = int'(codes[k]) * int'(FS_HIGH_MV) / int'(REF_STEPS);
            if (f == 0 && e > int'(FS_LOW_MV)) e = int'(FS_LOW_MV);
            check_val({10'h000, ref_c}, {10'h000, codes[k]}, "code");
            check_val({4'h0, mv}, e[15:0], "target");
            check_val({13'h0, fet, gl_en, j_g}, 16'h7, "on");
            check_val({15'h0, fs}, f[15:0], "scale");
         end
      end
   endtask
   task automatic t_plain_j();
      @(posedge clock_in);
      j_pwm <= 1'b1;
      wr(ADDR_CTRL1, 16'h0400);
      check_val({14'h0, fet, j_g}, 16'h0, "j gated");
      pwm_b <= 1'b1;
      clk(2);
      check_val({14'h0, fet, j_g}, 16'h1, "j plain");
   endtask
   task automatic t_pwm();
      @(posedge clock_in);
      {hs_on, h_on, h_pwm, pwm_a, pwm_b} <= {6'h3f, 4'b1110};
      wr(ADDR_CTRL2, 16'h00fe);
      wr(ADDR_CTRL1, 16'h0100);
      check_val({2'b0, h_g, dis_g, hs_g, ls_g}, 16'h1bc0, "pwm a");
      {pwm_a, pwm_b} <= 2'b01;
      clk(2);
      check_val({2'b0, h_g, dis_g, hs_g, ls_g}, 16'h2400, "pwm b");
      ls_on <= 6'h10;
      clk(2);
      check_val({2'b0, h_g, dis_g, hs_g, ls_g}, 16'h2000, "both");
      hs_on <= 6'h3e;
      wr(ADDR_CTRL2, 16'h0000);
      check_val({2'b0, h_g, dis_g, hs_g, ls_g}, 16'h3b80, "on bits");
      {hs_on, ls_on, h_on} <= 13'h0000;
   endtask
   task automatic t_refused();
      logic [15:0] r;
      wr(ADDR_CTRL1, 16'h05ff);
      wr(ADDR_CTRL2, 16'hffff);
      rd_chk(ADDR_CTRL1, 16'h05fe);
      rd_chk(ADDR_CTRL2, 16'hfeff);
      u_ecrpc_spi_master.xfer({OP_WRITE, ADDR_CTRL1, 16'h0}, 23, r);
      u_ecrpc_spi_master.xfer({2'h3, ADDR_CTRL1, 16'h0}, 24, r);
      wr(6'h05, 16'h1234);
      rd_chk(6'h05, 16'h0000);
      rd_chk(ADDR_CTRL1, 16'h05fe);
      wr(ADDR_CTRL2, 16'h0000);
   endtask
   task automatic t_ocr(input logic fast, input int per);
      int n;
      wr(ADDR_CTRL2, 16'h8000);
      {rec_fast, hs_on, oc} <= {fast, 6'h01, 7'h01};
      n = 0;
      wait_g0(1'b1, n);
      wait_g0(1'b0, n);
      wait_g0(1'b1, n);
      n = 0;
      wait_g0(1'b0, n);
      wait_g0(1'b1, n);
      check_val(n[15:0], per[15:0], "recovery period");
      oc <= 7'h00;
      rd_chk(ADDR_STATUS, 16'h0001);
      @(posedge clock_in);
      oc_clr <= 7'h01;
      @(posedge clock_in);
      {oc_clr, hs_on} <= 13'h0000;
      clk(1);
      check_val({9'h0, oc_st}, 16'h0000, "flag cleared");
   endtask
   // ==========================================================
   // Main sequence and watchdog
   initial begin
      repeat (12) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      clk(3);
      rd_chk(ADDR_CTRL1, CTRL_RESET);
      rd_chk(ADDR_CTRL2, CTRL_RESET);
      t_glass();
      t_plain_j();
      t_pwm();
      t_refused();
      t_ocr(1'b1, FAST);
      t_ocr(1'b0, SLOW);
      print_verdict();
   end
   initial begin
      #300000;
      miscompares++;
      print_verdict();
   end
endmodule
